// file: flash_host_defines.svh
// offsets, fields, command codes and timing counts of the flash host
`ifndef FLASH_HOST_DEFINES_SVH
`define FLASH_HOST_DEFINES_SVH
// apb register byte offsets
`define REG_CTRL      12'h000
`define REG_ADDR      12'h004
`define REG_WDATA     12'h008
`define REG_RDATA     12'h00c
`define REG_STATUS    12'h010
// ctrl register fields
`define CTRL_GO_BIT   0
`define CTRL_OP_LSB   4
`define CTRL_OP_W     4
`define CTRL_WP_BIT   8
`define CTRL_RST_BIT  9
`define CTRL_BYTE_BIT 10
`define CTRL_RESET    32'h0000_0200
// status register fields
`define STAT_BUSY_BIT 0
`define STAT_RDY_BIT  1
// device command codes
`define CMD_READ_ARRAY 8'hff
`define CMD_READ_ID    8'h90
`define CMD_READ_STAT  8'h70
`define CMD_CLR_STAT   8'h50
`define CMD_ERASE_BLK  8'h20
`define CMD_ERASE_CHIP 8'h30
`define CMD_CONFIRM    8'hd0
`define CMD_PROGRAM    8'h40
`define CMD_PROGRAM_ALT 8'h10
// identifier word addresses
`define ID_MAKER_ADDR  19'h00000
`define ID_PART_ADDR   19'h00001
`define ID_BLK_LOCK_OFS 19'h00002
`define ID_DEV_LOCK_ADDR 19'h00003
// device status bits
`define SR_READY      7
`define SR_ERASE_ERR  5
`define SR_PROG_ERR   4
`define SR_SUPPLY_ERR 3
`define SR_LOCK_ERR   1
// strobe timing in ns, cycles rounded up at 10 mhz
`define CLK_NS        100
`define T_STROBE_NS   100
`define T_STROBE_CYC  ((`T_STROBE_NS + `CLK_NS - 1) / `CLK_NS)
`define T_RECOVER_NS  100
`define T_RECOVER_CYC ((`T_RECOVER_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// file: flash_host_pkg.sv
// types of the flash host
package flash_host_pkg;
    typedef enum logic [3:0] {
        OP_READ_ARRAY = 4'h0,
        OP_READ_ID    = 4'h1,
        OP_READ_STAT  = 4'h2,
        OP_CLR_STAT   = 4'h3,
        OP_ERASE_BLK  = 4'h4,
        OP_ERASE_CHIP = 4'h5,
        OP_PROGRAM    = 4'h6,
        OP_READ       = 4'h7,
        OP_PROGRAM_ALT = 4'h8
    } host_op_t;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_CMD1  = 3'b001,
        ST_CMD2  = 3'b010,
        ST_READ  = 3'b011,
        ST_DONE  = 3'b100
    } host_state_t;
endpackage

// file: bus_cycle.sv
// one strobed write or read cycle on the flash pins
`timescale 1ns/1ns
`default_nettype none
module bus_cycle
    import flash_host_pkg::*;
#(
    parameter int STROBE_CYC = 1,
    parameter int RECOVER_CYC = 1
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic is_write,
    output logic strobe_ff,
    output logic sample,
    output logic done_ff
);
    localparam int CW = 4;
    logic [CW-1:0] cnt_ff;
    logic [1:0] ph_ff;
    wire strobe_end = (ph_ff == 2'd1) && (cnt_ff == 4'(STROBE_CYC - 1));
    wire rec_end = (ph_ff == 2'd2) && (cnt_ff == 4'(RECOVER_CYC - 1));
    wire rec_first = (ph_ff == 2'd2) && (cnt_ff == '0);
    // read data taken in the first recovery cycle: the two pin
    // synchroniser flops lag the read strobe by two edges
    assign sample = rec_first && !is_write;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ph_ff <= 2'd0;
            cnt_ff <= '0;
            strobe_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= rec_end;
            if (ph_ff == 2'd0 && start) begin
                ph_ff <= 2'd1;
                cnt_ff <= '0;
                strobe_ff <= 1'b1;
            end else if (strobe_end) begin
                // strobe falls here; the device latches data when the registered we_n pin rises one cycle later
                ph_ff <= 2'd2;
                cnt_ff <= '0;
                strobe_ff <= 1'b0;
            end else if (rec_end) begin
                ph_ff <= 2'd0;
            end else if (ph_ff != 2'd0) begin
                cnt_ff <= cnt_ff + 4'd1;
            end
        end
    end
endmodule // bus_cycle
`default_nettype wire

// file: flash_host.sv
// apb controlled host that drives a parallel flash through its pins
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none
`include "flash_host_defines.svh"
module flash_host
    import flash_host_pkg::*;
#(
    parameter int AW = 19,
    parameter int DW = 16
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [AW-1:0] fl_addr_ff,
    input wire logic [DW-1:0] fl_dq_in,
    output logic [DW-1:0] fl_dq_out_ff,
    output logic fl_dq_oe_n_ff,
    output logic fl_ce_n_ff,
    output logic fl_oe_n_ff,
    output logic fl_we_n_ff,
    output logic reset_powerdown_n_ff,
    output logic write_protect_ff,
    output logic byte_mode_n_ff,
    input wire logic ready_busy_in
);
    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [31:0] ctrl_ff, addr_ff, wdata_ff;
    logic [DW-1:0] rdata_ff, dq_s1_ff, dq_s2_ff;
    logic rb_s1_ff, rb_s2_ff;
    logic busy_ff, pready_ff, pslverr_ff;
    logic [31:0] prdata_ff;
    host_state_t state_ff, nxt_state;
    logic is_write_ff;
    logic cyc_start_ff;
    logic ce_hold_ff;
    wire cyc_strobe, cyc_sample, cyc_done;

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    wire acc = psel && penable && !pready_ff;
    wire wr = acc && pwrite;
    wire hit_ctrl = paddr == `REG_CTRL;
    wire hit_addr = paddr == `REG_ADDR;
    wire hit_wdata = paddr == `REG_WDATA;
    wire hit_rdata = paddr == `REG_RDATA;
    wire hit_stat = paddr == `REG_STATUS;
    wire hit_any = hit_ctrl | hit_addr | hit_wdata | hit_rdata | hit_stat;
    // orders are refused while a sequence runs, pslverr says so
    wire go = wr && hit_ctrl && pwdata[`CTRL_GO_BIT] && !busy_ff;
    wire [`CTRL_OP_W-1:0] go_op = pwdata[`CTRL_OP_LSB +: `CTRL_OP_W];
    wire [31:0] stat_word = {30'h0, rb_s2_ff, busy_ff};
    wire [31:0] rd_mux = hit_ctrl ? ctrl_ff :
                         hit_addr ? addr_ff :
                         hit_wdata ? wdata_ff :
                         hit_rdata ? {{(32-DW){1'b0}}, rdata_ff} :
                         hit_stat ? stat_word : 32'h0;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0;
        end else begin
            pready_ff <= acc;
            pslverr_ff <= acc && (!hit_any || (wr && hit_ctrl && busy_ff));
            prdata_ff <= acc ? rd_mux : 32'h0;
        end
    end
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign prdata = prdata_ff;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctrl_ff <= `CTRL_RESET;
            addr_ff <= 32'h0;
            wdata_ff <= 32'h0;
        end else begin
            if (wr && hit_ctrl && !busy_ff)
                ctrl_ff <= {pwdata[31:1], 1'b0};
            if (wr && hit_addr && !busy_ff)
                addr_ff <= pwdata;
            if (wr && hit_wdata && !busy_ff)
                wdata_ff <= pwdata;
        end
    end

    // ------------------------------------------------------------------
    // pin input synchronisers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            dq_s1_ff <= '0;
            dq_s2_ff <= '0;
            rb_s1_ff <= 1'b0;
            rb_s2_ff <= 1'b0;
        end else begin
            dq_s1_ff <= fl_dq_in;
            dq_s2_ff <= dq_s1_ff;
            // floating ready_busy is pulled high outside: high means ready
            rb_s1_ff <= ready_busy_in;
            rb_s2_ff <= rb_s1_ff;
        end
    end

    // ------------------------------------------------------------------
    // command sequencing
    // ------------------------------------------------------------------
    host_op_t op_ff;
    wire two_write = (op_ff == OP_ERASE_BLK) || (op_ff == OP_ERASE_CHIP) ||
                     (op_ff == OP_PROGRAM) || (op_ff == OP_PROGRAM_ALT);
    wire plain_read = op_ff == OP_READ;
    logic [7:0] first_code;
    always_comb begin
        case (op_ff)
            OP_READ_ARRAY: first_code = `CMD_READ_ARRAY;
            OP_READ_ID: first_code = `CMD_READ_ID;
            OP_READ_STAT: first_code = `CMD_READ_STAT;
            OP_CLR_STAT: first_code = `CMD_CLR_STAT;
            OP_ERASE_BLK: first_code = `CMD_ERASE_BLK;
            OP_ERASE_CHIP: first_code = `CMD_ERASE_CHIP;
            OP_PROGRAM: first_code = `CMD_PROGRAM;
            OP_PROGRAM_ALT: first_code = `CMD_PROGRAM_ALT;
            default: first_code = `CMD_READ_ARRAY;
        endcase
    end
    // second write: confirm for erases, target data for program
    wire [DW-1:0] second_data = (op_ff == OP_PROGRAM ||
                                 op_ff == OP_PROGRAM_ALT) ?
                                wdata_ff[DW-1:0] :
                                {{(DW-8){1'b0}}, `CMD_CONFIRM};

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: if (go) nxt_state = ST_CMD1;
            ST_CMD1: if (cyc_done)
                nxt_state = two_write ? ST_CMD2 : ST_DONE;
            ST_CMD2: if (cyc_done) nxt_state = ST_DONE;
            ST_READ: if (cyc_done) nxt_state = ST_DONE;
            ST_DONE: nxt_state = ST_IDLE;
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
            op_ff <= OP_READ_ARRAY;
            busy_ff <= 1'b0;
            cyc_start_ff <= 1'b0;
            is_write_ff <= 1'b0;
            rdata_ff <= '0;
        end else begin
            state_ff <= (go && go_op == OP_READ) ? ST_READ : nxt_state;
            if (go)
                op_ff <= host_op_t'(go_op);
            busy_ff <= go || (state_ff != ST_IDLE && state_ff != ST_DONE);
            cyc_start_ff <= go || (state_ff == ST_CMD1 && cyc_done &&
                                   two_write);
            if (go)
                is_write_ff <= go_op != OP_READ;
            // status, id or array data per device mode; the device chooses
            if (cyc_sample && plain_read)
                rdata_ff <= dq_s2_ff;
        end
    end

    bus_cycle #(
        .STROBE_CYC(`T_STROBE_CYC + 2),
        .RECOVER_CYC(`T_RECOVER_CYC)
    ) u_cycle (
        .mclk(mclk),
        .rst_n(rst_n),
        .start(cyc_start_ff),
        .is_write(is_write_ff),
        .strobe_ff(cyc_strobe),
        .sample(cyc_sample),
        .done_ff(cyc_done)
    );

    // ------------------------------------------------------------------
    // pins
    // ------------------------------------------------------------------
    // ce and oe rise after every read, so a status latch refreshes
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            fl_addr_ff <= '0;
            fl_dq_out_ff <= '0;
            ce_hold_ff <= 1'b0;
            fl_dq_oe_n_ff <= 1'b1;
            fl_ce_n_ff <= 1'b1;
            fl_oe_n_ff <= 1'b1;
            fl_we_n_ff <= 1'b1;
            reset_powerdown_n_ff <= 1'b0;
            write_protect_ff <= 1'b0;
            byte_mode_n_ff <= 1'b1;
        end else begin
            fl_addr_ff <= addr_ff[AW-1:0];
            fl_dq_out_ff <= (state_ff == ST_CMD2) ? second_data :
                            {{(DW-8){1'b0}}, first_code};
            // ce and dq stay one cycle past the rising write strobe so
            // the device latches data with hold time to spare
            ce_hold_ff <= cyc_strobe;
            fl_dq_oe_n_ff <= !((cyc_strobe || ce_hold_ff) && is_write_ff);
            fl_ce_n_ff <= !(cyc_strobe || ce_hold_ff);
            fl_oe_n_ff <= !(cyc_strobe && !is_write_ff);
            fl_we_n_ff <= !(cyc_strobe && is_write_ff);
            reset_powerdown_n_ff <= !ctrl_ff[`CTRL_RST_BIT];
            write_protect_ff <= ctrl_ff[`CTRL_WP_BIT];
            byte_mode_n_ff <= !ctrl_ff[`CTRL_BYTE_BIT];
        end
    end
endmodule // flash_host
`default_nettype wire

// file: flash_dev_model.sv
// behavioural parallel flash device facing the host
`timescale 1ns/1ns
`default_nettype none
module flash_dev_model #(
    parameter logic [7:0] MAKER = 8'h5c, // arbitrary value
    parameter logic [7:0] PART = 8'h3a // arbitrary value
) (
    input wire logic [18:0] addr,
    input wire logic [15:0] dq_o,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic rp_n,
    input wire logic wp,
    output logic [15:0] dq_i,
    output wire logic ready_busy
);
    // ----
    // four word blocks, block zero is the boot block
    // ----
    logic [15:0] mem [16];
    logic [15:0] rd;
    logic [15:0] held;
    logic [7:0] sr;
    logic [7:0] sr_lat;
    logic [7:0] pend;
    logic [1:0] mode;
    logic busy;
    function automatic logic locked(input logic [3:0] a);
        return a[3:2] == 2'h0 && !wp;
    endfunction
    initial foreach (mem[i]) mem[i] = 16'hffff;
    assign ready_busy = busy ? 1'b0 : 1'bz;
    always @(rp_n) if (!rp_n) begin
        mode = 2'h0;
        sr = 8'h80;
        pend = 8'h00;
        busy = 1'b0;
    end
    always @(posedge we_n) if (!ce_n && rp_n) begin
        if (pend != 8'h00) begin
            if (pend == 8'h40 || pend == 8'h10) begin
                if (locked(addr[3:0])) sr = sr | 8'h12;
                else mem[addr[3:0]] = mem[addr[3:0]] & dq_o;
            end else if (dq_o[7:0] != 8'hd0) sr = sr | 8'h30;
            else if (pend == 8'h20 && locked(addr[3:0])) sr = sr | 8'h22;
            else for (int i = 0; i < 16; i++)
                if ((pend == 8'h30 || i[3:2] == addr[3:2]) && !locked(i[3:0]))
                    mem[i] = 16'hffff;
            pend = 8'h00;
            sr[7] = 1'b0;
            busy = 1'b1;
            busy <= #200 1'b0;
            sr[7] <= #200 1'b1;
        end else case (dq_o[7:0])
            8'hff: if (!busy) mode = 2'h0;
            8'h90: mode = 2'h1;
            8'h70: mode = 2'h2;
            8'h50: sr = sr & 8'hc5;
            8'h20, 8'h30, 8'h40, 8'h10: begin
                pend = dq_o[7:0];
                mode = 2'h2;
            end
            default: ;
        endcase
    end
    always @(negedge oe_n or negedge ce_n) sr_lat = sr;
    always_comb begin
        if (mode == 2'h0) rd = mem[addr[3:0]];
        else if (mode == 2'h2) rd = {8'h00, sr_lat};
        else if (addr == 19'h0) rd = {8'h00, MAKER};
        else if (addr == 19'h1) rd = {8'h00, PART};
        else rd = {15'h0, addr[1:0] == 2'h2 && locked(addr[3:0])};
    end
    // released bus shows the inverse so a stale value never matches
    always @(posedge oe_n) held = rd;
    assign dq_i = !ce_n && !oe_n ? rd : ~held;
endmodule // flash_dev_model
`default_nettype wire

// file: flash_host_sva.sv
// port assertions for the flash host
`timescale 1ns/1ns
`default_nettype none
module flash_host_sva #(
    parameter int AW = 19,
    parameter int DW = 16
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [AW-1:0] fl_addr_ff,
    input wire logic [DW-1:0] fl_dq_out_ff,
    input wire logic fl_dq_oe_n_ff,
    input wire logic fl_ce_n_ff,
    input wire logic fl_oe_n_ff,
    input wire logic fl_we_n_ff,
    input wire logic reset_powerdown_n_ff
);
    // ----
    // bus answer and strobe shapes
    // ----
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    AST_RESET_PINS:
        assert property ($rose(rst_n) |-> fl_ce_n_ff && fl_we_n_ff
            && fl_oe_n_ff && fl_dq_oe_n_ff && !reset_powerdown_n_ff)
        else $error("pins not idle after reset");
    AST_ONE_WAIT:
        assert property (psel && penable && !pready |=> pready)
        else $error("no answer after access");
    AST_PULSE:
        assert property (pready |=> !pready)
        else $error("pready too long");
    AST_ERR_QUAL:
        assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_READ_PINS:
        assert property (!fl_oe_n_ff |-> !fl_ce_n_ff && fl_we_n_ff
            && fl_dq_oe_n_ff)
        else $error("bad pins in read");
    AST_WRITE_PINS:
        assert property (!fl_we_n_ff |-> !fl_ce_n_ff && fl_oe_n_ff
            && !fl_dq_oe_n_ff)
        else $error("bad pins in write");
    AST_WE_WIDTH:
        assert property ($fell(fl_we_n_ff) |-> (!fl_we_n_ff) [*3] ##1 fl_we_n_ff)
        else $error("write strobe width");
    AST_OE_WIDTH:
        assert property ($fell(fl_oe_n_ff) |-> (!fl_oe_n_ff) [*3] ##1 fl_oe_n_ff)
        else $error("read strobe width");
    AST_WE_HOLD:
        assert property (!fl_we_n_ff && !$fell(fl_we_n_ff) |->
            $stable(fl_dq_out_ff) && $stable(fl_addr_ff))
        else $error("write data moved");
    AST_CE_HOLD:
        assert property ($rose(fl_we_n_ff) |-> !fl_ce_n_ff && !fl_dq_oe_n_ff)
        else $error("write data not held past strobe");
    COV_WRITE: cover property ($rose(fl_we_n_ff));
    COV_READ: cover property ($rose(fl_oe_n_ff));
    COV_ERR: cover property (pslverr);
endmodule // flash_host_sva
`default_nettype wire

// file: flash_command_user_interface_tb.sv
// bench of the flash host against a behavioural flash device
`timescale 1ns/1ns
`default_nettype none
`include "flash_host_defines.svh"
module flash_command_user_interface_tb;
    import flash_host_pkg::*;
    typedef struct {
        host_op_t op;
        logic [18:0] a;
        logic [15:0] d;
        logic [15:0] e;
    } row_t;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready;
    logic pslverr;
    logic err;
    logic wpb = 1'b1;
    logic [18:0] fl_addr_ff;
    logic [15:0] fl_dq_out_ff;
    logic [15:0] dev_dq;
    logic fl_dq_oe_n_ff;
    logic fl_ce_n_ff;
    logic fl_oe_n_ff;
    logic fl_we_n_ff;
    logic reset_powerdown_n_ff;
    logic write_protect_ff;
    logic byte_mode_n_ff;
    wire logic [15:0] dq_bus;
    tri1 ready_busy;
    int num_errors = 0;
    int num_checks = 0;
    int cyc = 0;
    row_t rows [20] = '{
        '{OP_READ, 19'h5, 16'h0, 16'hffff},
        '{OP_PROGRAM, 19'h5, 16'h1234, 16'h0},
        '{OP_READ, 19'h5, 16'h0, 16'h0080},
        '{OP_READ_ARRAY, 19'h0, 16'h0, 16'h0},
        '{OP_READ, 19'h5, 16'h0, 16'h1234},
        '{OP_PROGRAM_ALT, 19'h5, 16'hff30, 16'h0},
        '{OP_READ_ARRAY, 19'h0, 16'h0, 16'h0},
        '{OP_READ, 19'h5, 16'h0, 16'h1230},
        '{OP_READ_ID, 19'h0, 16'h0, 16'h0},
        '{OP_READ, 19'h0, 16'h0, 16'h005c},
        '{OP_READ, 19'h1, 16'h0, 16'h003a},
        '{OP_READ, 19'h3, 16'h0, 16'h0},
        '{OP_READ, 19'h6, 16'h0, 16'h0},
        '{OP_ERASE_BLK, 19'h4, 16'h0, 16'h0},
        '{OP_READ_ARRAY, 19'h0, 16'h0, 16'h0},
        '{OP_READ, 19'h5, 16'h0, 16'hffff},
        '{OP_PROGRAM, 19'h9, 16'h0, 16'h0},
        '{OP_ERASE_CHIP, 19'h0, 16'h0, 16'h0},
        '{OP_READ_ARRAY, 19'h0, 16'h0, 16'h0},
        '{OP_READ, 19'h9, 16'h0, 16'hffff}
    };
    assign dq_bus = fl_dq_oe_n_ff ? dev_dq : fl_dq_out_ff;
    flash_host dut_u (.mclk(mclk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fl_addr_ff(fl_addr_ff), .fl_dq_in(dq_bus),
        .fl_dq_out_ff(fl_dq_out_ff), .fl_dq_oe_n_ff(fl_dq_oe_n_ff),
        .fl_ce_n_ff(fl_ce_n_ff), .fl_oe_n_ff(fl_oe_n_ff),
        .fl_we_n_ff(fl_we_n_ff),
        .reset_powerdown_n_ff(reset_powerdown_n_ff),
        .write_protect_ff(write_protect_ff),
        .byte_mode_n_ff(byte_mode_n_ff),
        .ready_busy_in(ready_busy));
    flash_dev_model dev_u (.addr(fl_addr_ff), .dq_o(dq_bus),
        .ce_n(fl_ce_n_ff), .oe_n(fl_oe_n_ff), .we_n(fl_we_n_ff),
        .rp_n(reset_powerdown_n_ff), .wp(write_protect_ff),
        .dq_i(dev_dq), .ready_busy(ready_busy));
    // ----
    // bus tasks and checks
    // ----
    always #50 mclk = ~mclk;
    task automatic finish_test();
        $display("errors %0d checks %0d", num_errors, num_checks);
        if (num_errors == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            num_errors++;
            finish_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // one idle cycle after each transfer keeps psel from two drives
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic idle();
        do apb(1'b0, `REG_STATUS, 32'h0); while (rd[`STAT_BUSY_BIT] !== 1'b0);
    endtask
    task automatic run(input host_op_t op, input logic [18:0] a,
        input logic [15:0] d);
        apb(1'b1, `REG_ADDR, {13'h0, a});
        apb(1'b1, `REG_WDATA, {16'h0, d});
        apb(1'b1, `REG_CTRL, {23'h0, wpb, op, 4'h1});
        idle();
        if (op == OP_READ) apb(1'b0, `REG_RDATA, 32'h0);
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        chk({31'h0, reset_powerdown_n_ff}, 32'h0);
        apb(1'b0, `REG_CTRL, 32'h0);
        chk(rd, 32'h200);
        foreach (rows[i]) begin
            run(rows[i].op, rows[i].a, rows[i].d);
            if (rows[i].op == OP_READ) chk(rd, {16'h0, rows[i].e});
        end
        wpb = 1'b0;
        run(OP_PROGRAM, 19'h1, 16'h0);
        run(OP_READ, 19'h0, 16'h0);
        chk(rd, 32'h92);
        run(OP_ERASE_BLK, 19'h0, 16'h0);
        run(OP_READ, 19'h0, 16'h0);
        chk(rd, 32'hb2);
        run(OP_CLR_STAT, 19'h0, 16'h0);
        run(OP_READ, 19'h0, 16'h0);
        chk(rd, 32'h80);
        run(OP_READ_ID, 19'h0, 16'h0);
        run(OP_READ, 19'h2, 16'h0);
        chk(rd, 32'h1);
        apb(1'b0, 12'h020, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, `REG_CTRL, {24'h0, OP_READ_STAT, 4'h1});
        apb(1'b1, `REG_CTRL, {24'h0, OP_READ_STAT, 4'h1});
        chk({31'h0, err}, 32'h1);
        idle();
        run(OP_READ, 19'h0, 16'h0);
        chk(rd, 32'h80);
        apb(1'b0, `REG_STATUS, 32'h0);
        chk(rd, 32'h2);
        apb(1'b1, `REG_CTRL, 32'h0000_0400);
        chk({31'h0, byte_mode_n_ff}, 32'h0);
        // second reset, with byte mode set and no sequence running, must bring every pin back to idle
        rst_n <= 1'b0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        chk({31'h0, byte_mode_n_ff}, 32'h1);
        chk({31'h0, reset_powerdown_n_ff}, 32'h0);
        apb(1'b0, `REG_CTRL, 32'h0);
        chk(rd, 32'h200);
        finish_test();
    end
endmodule // flash_command_user_interface_tb
bind flash_host flash_host_sva #(.AW(AW), .DW(DW)) sva_u (.mclk(mclk),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .fl_addr_ff(fl_addr_ff),
    .fl_dq_out_ff(fl_dq_out_ff), .fl_dq_oe_n_ff(fl_dq_oe_n_ff),
    .fl_ce_n_ff(fl_ce_n_ff), .fl_oe_n_ff(fl_oe_n_ff),
    .fl_we_n_ff(fl_we_n_ff), .reset_powerdown_n_ff(reset_powerdown_n_ff));
`default_nettype wire
